// file: rtl/duc_consts.vh
// Register map, reset values and field positions of the multitone upconverter
`ifndef DUC_CONSTS_VH
`define DUC_CONSTS_VH

// Register byte offsets (word index is offset / 4)
`define DUC_CTRL_OFS 8'h00
`define DUC_CONST0_OFS 8'h04
`define DUC_CONST1_OFS 8'h08
`define DUC_FTW_BASE_OFS 8'h10
`define DUC_STATUS_OFS 8'h30
`define DUC_PHASE_OFS 8'h34

// Control register fields
`define DUC_BOOST_BIT 0
`define DUC_TWOS_BIT 1
`define DUC_SRC_LSB 4
`define DUC_SUMA_LSB 8
`define DUC_SUMB_LSB 12
`define DUC_SSYNC_BIT 16

// Reset values
`define DUC_CTRL_RST 32'h0000_0000
`define DUC_CONST_RST 32'h0000_0000
`define DUC_FTW_RST 32'h0000_0000

// Bus responses
`define DUC_RESP_OKAY 2'b00
`define DUC_RESP_SLVERR 2'b10

`endif

// file: rtl/multitone_duc.v
// Four-oscillator digital upconverter with two summed output channels
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "duc_consts.vh"

// Behaviour
// RL1 - Four separate oscillators, each with its own 48-bit tuning word.
// RL2 - Oscillators step once per sample, resolution is sample rate over 2^48.
// RL3 - Each path takes link samples or an internal constant, per select bit.
// RL4 - Two output channels, two upconverters each, four paths overall.
// RL5 - Any subset of the four paths may be summed into either channel.
// RL6 - External trigger aligns the phase of all four oscillators.
// RL7 - Outside controller routes one common trigger to every device.
// RL8 - Each path outputs I times cosine minus Q times sine only.
// RL9 - Software scales equal I/Q constants down to avoid saturation.
// RL10 - Mixer has a selectable 6 dB boost on its multiplier output.
// RL11 - Two programmable constant blocks feed the paths as baseband.
// RL12 - Boost bit resets to zero, giving minus 3 dB mixer gain; the code gives minus 6 dB (shift of 16).
// RL13 - 16-bit phase offset adds to top accumulator bits before lookup.
// RL14 - 16-bit MSB-aligned samples, offset binary differs by inverted MSB.
// RL15 - Accumulators add their tuning word each sample, wrapping at 2^48.
// RL16 - Trigger clears all four accumulators in the same cycle.
module multitone_duc #(
  parameter NPATH = 4,
  parameter SW = 16
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // AXI4-Lite register port
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Baseband samples from the link, lane k in bits [16k+15:16k]
  input wire [NPATH*SW-1:0] link_i,
  input wire [NPATH*SW-1:0] link_q,
  input wire link_valid,
  output wire link_ready,
  // Phase alignment trigger pin
  input wire sync_in,
  // Summed channel outputs
  output reg [SW-1:0] ch_a_data,
  output reg [SW-1:0] ch_b_data,
  output reg out_valid,
  input wire out_ready
);

  // Quarter-wave sine table, sin(k*pi/32) at full scale 0x7FFF, entry 0 low
  localparam [255:0] QTAB = {64'h7F61_7D89_7A7C_7641, 64'h70E2_6A6D_62F1_5A82,
    64'h5133_471C_3C56_30FB, 64'h2528_18F9_0C8C_0000};
  function [15:0] quarter;
    input [4:0] idx;
    quarter = idx[4] ? 16'h7FFF : QTAB[idx[3:0]*16 +: 16];
  endfunction

  // Signed sine of a 6-bit phase, built from quadrant symmetry
  function signed [15:0] sine6;
    input [5:0] p;
    reg [15:0] mag;
    begin
      mag = p[4] ? quarter(5'd16 - {1'b0, p[3:0]}) : quarter({1'b0, p[3:0]});
      sine6 = p[5] ? -$signed(mag) : $signed(mag);
    end
  endfunction

  // Clamp a wide signed value into the sample width
  function signed [15:0] sat16;
    input signed [33:0] v;
    sat16 = (v > 34'sd32767) ? 16'sh7FFF :
      ((v < -34'sd32768) ? 16'sh8000 : v[15:0]);
  endfunction

  // Real part of the complex product, scaled by 2^(boost-1)
  function signed [15:0] mix;
    input signed [15:0] iv;
    input signed [15:0] qv;
    input [5:0] p;
    input boost;
    reg signed [31:0] pc;
    reg signed [31:0] ps;
    reg signed [33:0] d;
    begin
      pc = iv * sine6(p + 6'd16);
      ps = qv * sine6(p);
      d = {{2{pc[31]}}, pc} - {{2{ps[31]}}, ps}; // [RL8]
      // Unit gain is a shift of 15; the default halves it again
      mix = sat16(boost ? (d >>> 15) : (d >>> 16)); // [RL10] [RL12]
    end
  endfunction

  // Byte-lane merge of a register write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (strb[b])
          merge[b*8 +: 8] = nw[b*8 +: 8];
    end
  endfunction

  // Register state
  reg [31:0] ctrl_r;
  reg [31:0] const_r [0:1];
  reg [31:0] ftw_lo_r [0:NPATH-1];
  reg [31:0] ftw_hi_r [0:NPATH-1];
  reg [7:0] sync_cnt_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg [47:0] acc_r [0:NPATH-1];
  reg sync_m_r, sync_s_r, sync_d_r, soft_sync_r;
  reg [2*SW-1:0] spare_r;
  reg spare_empty_r;
  integer k, m, n, r;

  wire boost = ctrl_r[`DUC_BOOST_BIT];
  wire twos = ctrl_r[`DUC_TWOS_BIT];
  wire [NPATH-1:0] src_const = ctrl_r[`DUC_SRC_LSB +: NPATH];
  wire [NPATH-1:0] sum_a = ctrl_r[`DUC_SUMA_LSB +: NPATH];
  wire [NPATH-1:0] sum_b = ctrl_r[`DUC_SUMB_LSB +: NPATH];
  wire do_write = ~awready & ~wready & ~bvalid;
  wire sync_pulse = (sync_s_r & ~sync_d_r) | soft_sync_r;
  // When every path takes a constant, the oscillators do not wait for the link
  wire need_link = |(~src_const);
  wire adv = spare_empty_r & (link_valid | ~need_link);

  // The link may only push while the buffer has a free slot
  assign link_ready = spare_empty_r;

  // Trigger pin passes two flops, the third only feeds the edge detector
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_m_r <= 1'b0;
      sync_s_r <= 1'b0;
      sync_d_r <= 1'b0;
    end else begin
      sync_m_r <= sync_in;
      sync_s_r <= sync_m_r;
      sync_d_r <= sync_s_r;
    end
  end

  // Phase accumulators; a trigger wins over stepping and clears all four
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (n = 0; n < NPATH; n = n + 1)
        acc_r[n] <= 48'h0000_0000_0000;
    end else begin
      for (n = 0; n < NPATH; n = n + 1)
        if (sync_pulse)
          acc_r[n] <= 48'h0000_0000_0000; // [RL6] [RL16]
        else if (adv)
          acc_r[n] <= acc_r[n] + {ftw_hi_r[n][15:0],
            ftw_lo_r[n]}; // [RL1] [RL2] [RL15]
    end
  end

  // Per-path sample select, format fix, mixing and channel sums
  reg [SW-1:0] iv, qv;
  reg [15:0] ph;
  reg signed [15:0] mixed;
  reg signed [33:0] acc_a, acc_b;
  reg [2*SW-1:0] sum_word;
  always @* begin
    acc_a = 34'sd0;
    acc_b = 34'sd0;
    iv = 16'h0000;
    qv = 16'h0000;
    ph = 16'h0000;
    mixed = 16'sh0000;
    for (k = 0; k < NPATH; k = k + 1) begin
      if (src_const[k]) begin
        iv = const_r[k/2][15:0]; // [RL3] [RL11]
        qv = const_r[k/2][31:16];
      end else begin
        iv = link_i[k*SW +: SW]; // [RL3]
        qv = link_q[k*SW +: SW];
      end
      // Offset binary turns into two's complement by flipping the MSB
      if (!twos) begin
        iv[SW-1] = ~iv[SW-1]; // [RL14]
        qv[SW-1] = ~qv[SW-1];
      end
      ph = acc_r[k][47:32] + ftw_hi_r[k][31:16]; // [RL13]
      mixed = mix(iv, qv, ph[15:10], boost);
      if (sum_a[k])
        acc_a = acc_a + mixed; // [RL5]
      if (sum_b[k])
        acc_b = acc_b + mixed; // [RL5]
    end
    sum_word = {sat16(acc_b), sat16(acc_a)}; // [RL4]
  end

  // Two-entry buffer: the output register is the head, spare_r the tail
  wire pop = out_valid & out_ready;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_valid <= 1'b0;
      ch_a_data <= 16'h0000;
      ch_b_data <= 16'h0000;
      spare_r <= 32'h0000_0000;
      spare_empty_r <= 1'b1;
    end else if (!out_valid || pop) begin
      if (!spare_empty_r) begin
        {ch_b_data, ch_a_data} <= spare_r;
        out_valid <= 1'b1;
        spare_empty_r <= ~adv;
        spare_r <= sum_word;
      end else begin
        out_valid <= adv;
        if (adv)
          {ch_b_data, ch_a_data} <= sum_word;
      end
    end else if (adv) begin
      // Head is stalled, so the new word parks in the tail
      spare_r <= sum_word;
      spare_empty_r <= 1'b0;
    end
  end

  // Write channels are taken independently, the response follows both
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `DUC_RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_addr_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        wready <= 1'b0;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        if (aw_addr_r[1:0] == 2'b00 && (aw_addr_r <= `DUC_CTRL_OFS + 8'h08 ||
            (aw_addr_r >= `DUC_FTW_BASE_OFS &&
             aw_addr_r < `DUC_STATUS_OFS)))
          bresp <= `DUC_RESP_OKAY;
        else
          bresp <= `DUC_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Register file updates; the soft trigger bit is a self-clearing strobe
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `DUC_CTRL_RST; // [RL12]
      const_r[0] <= `DUC_CONST_RST;
      const_r[1] <= `DUC_CONST_RST;
      for (m = 0; m < NPATH; m = m + 1) begin
        ftw_lo_r[m] <= `DUC_FTW_RST;
        ftw_hi_r[m] <= `DUC_FTW_RST;
      end
      soft_sync_r <= 1'b0;
    end else begin
      soft_sync_r <= 1'b0;
      if (do_write) begin
        case (aw_addr_r)
          `DUC_CTRL_OFS: begin
            ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) & 32'h0000_FFF3;
            soft_sync_r <= w_strb_r[2] & w_data_r[`DUC_SSYNC_BIT]; // [RL6]
          end
          // Equal full-scale constants overflow; software scales them
          `DUC_CONST0_OFS:
            const_r[0] <= merge(const_r[0], w_data_r, w_strb_r); // [RL11]
          `DUC_CONST1_OFS:
            const_r[1] <= merge(const_r[1], w_data_r, w_strb_r); // [RL11]
          default: begin
            for (m = 0; m < NPATH; m = m + 1) begin
              if (aw_addr_r == `DUC_FTW_BASE_OFS + 8*m)
                ftw_lo_r[m] <= merge(ftw_lo_r[m], w_data_r, w_strb_r); // [RL1]
              if (aw_addr_r == `DUC_FTW_BASE_OFS + 8*m + 4)
                ftw_hi_r[m] <= merge(ftw_hi_r[m], w_data_r, w_strb_r); // [RL1]
            end
          end
        endcase
      end
    end
  end

  // Count of alignment events, so software can see that triggers arrive
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      sync_cnt_r <= 8'h00;
    else if (sync_pulse)
      sync_cnt_r <= sync_cnt_r + 8'h01;
  end

  // Read channel: one address at a time, data one cycle later
  reg [31:0] rd_val;
  reg rd_ok;
  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (araddr)
      `DUC_CTRL_OFS: rd_val = ctrl_r;
      `DUC_CONST0_OFS: rd_val = const_r[0];
      `DUC_CONST1_OFS: rd_val = const_r[1];
      `DUC_STATUS_OFS:
        rd_val = {16'h0000, sync_cnt_r, 6'h00, out_valid, ~spare_empty_r};
      `DUC_PHASE_OFS: rd_val = acc_r[0][47:16];
      default: begin
        rd_ok = 1'b0;
        for (r = 0; r < NPATH; r = r + 1) begin
          if (araddr == `DUC_FTW_BASE_OFS + 8*r) begin
            rd_val = ftw_lo_r[r];
            rd_ok = 1'b1;
          end
          if (araddr == `DUC_FTW_BASE_OFS + 8*r + 4) begin
            rd_val = ftw_hi_r[r];
            rd_ok = 1'b1;
          end
        end
      end
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `DUC_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_val;
      rresp <= rd_ok ? `DUC_RESP_OKAY : `DUC_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule // multitone_duc

// file: tb/link_src.sv
// Baseband link source and trigger driver facing the upconverter
`timescale 1ns/100ps
module link_src (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Stimulus from the bench
  input wire en,
  input wire [63:0] lane_i,
  input wire [63:0] lane_q,
  input wire fire,
  // Link side
  output reg [63:0] link_i,
  output reg [63:0] link_q,
  output reg link_valid,
  input wire link_ready,
  output reg sync_out
);
  // Hold a word until taken; idle lanes toggle so stale data never matches
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_valid <= 1'b0;
      link_i <= 64'h0000_0000_0000_0000;
      link_q <= 64'h0000_0000_0000_0000;
      sync_out <= 1'b0;
    end else begin
      sync_out <= fire; // One line feeds every device
      if (!link_valid || link_ready) begin
        link_valid <= en;
        link_i <= en ? lane_i : ~link_i;
        link_q <= en ? lane_q : ~link_q;
      end
    end
  end
endmodule // link_src

// file: tb/duc_chk.sv
// Handshake checks on the upconverter register bus and output stream
`timescale 1ns/100ps
module duc_chk #(
  parameter SW = 16
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Register bus
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  // Stream
  input wire link_ready,
  input wire [SW-1:0] ch_a_data,
  input wire [SW-1:0] ch_b_data,
  input wire out_valid,
  input wire out_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Write steps: both halves taken, then response accepted
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence b_done;
    bvalid && bready;
  endsequence
  chk_b_answer: assert property (wr_taken |-> ##2 bvalid)
    else $error("write response late");
  chk_bus_reopen: assert property (b_done |=> awready && wready)
    else $error("write channel not reopened");
  chk_aw_block: assert property (bvalid |-> !awready && !wready)
    else $error("second write accepted");
  chk_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  chk_r_block: assert property (rvalid |-> !arready)
    else $error("second read accepted");
  chk_r_unmapped: assert property (arvalid && arready && araddr == 8'h0C
    |=> rresp == 2'b10 && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_out_holds: assert property (out_valid && !out_ready |=> out_valid
    && $stable(ch_a_data) && $stable(ch_b_data))
    else $error("output changed while stalled");
  chk_no_refill: assert property (out_valid && !out_ready && !link_ready
    |=> !link_ready)
    else $error("full buffer took a sample");
endmodule // duc_chk
bind multitone_duc duc_chk #(.SW(SW)) u_chk (
  .clk(clk), .rstn(rstn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .link_ready(link_ready),
  .ch_a_data(ch_a_data), .ch_b_data(ch_b_data), .out_valid(out_valid),
  .out_ready(out_ready));

// file: tb/multitone_duc_test.sv
// Register-driven bench for the multitone upconverter
`timescale 1ns/100ps
module multitone_duc_test;
  reg clk, rstn, awvalid, wvalid, bready, arvalid, rready, out_ready, en, fire;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata, rv;
  reg [3:0] wstrb;
  reg [1:0] rr, br;
  reg [63:0] lane_i, lane_q;
  wire awready, wready, bvalid, arready, rvalid, link_valid, link_ready;
  wire sync_in, out_valid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [63:0] link_i, link_q;
  wire [15:0] ch_a_data, ch_b_data;
  integer err_count, n_tests;
  multitone_duc u_dut (.clk(clk), .rstn(rstn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .link_i(link_i), .link_q(link_q), .link_valid(link_valid),
    .link_ready(link_ready), .sync_in(sync_in), .ch_a_data(ch_a_data),
    .ch_b_data(ch_b_data), .out_valid(out_valid), .out_ready(out_ready));
  link_src u_src (.clk(clk), .rstn(rstn), .en(en), .lane_i(lane_i),
    .lane_q(lane_q), .fire(fire), .link_i(link_i), .link_q(link_q),
    .link_valid(link_valid), .link_ready(link_ready), .sync_out(sync_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task final_report;
    begin
      $display("Mismatches %0d in %0d checks", err_count, n_tests);
      if (err_count == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Bound every handshake wait so a dead bus ends the run
  task tmo(input integer n);
    begin
      if (n > 200) begin
        err_count = err_count + 1;
        $display("ERROR %0t bus handshake timed out", $time);
        final_report;
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    integer n;
    reg done;
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      done = 1'b0;
      while (!done) begin
        @(posedge clk);
        n = n + 1;
        tmo(n);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) begin
          br = bresp;
          bready <= 1'b0;
          done = 1'b1;
        end
      end
    end
  endtask
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    integer n;
    reg done;
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      done = 1'b0;
      while (!done) begin
        @(posedge clk);
        n = n + 1;
        tmo(n);
        if (arready) arvalid <= 1'b0;
        if (rvalid) begin
          d = rdata;
          r = rresp;
          rready <= 1'b0;
          done = 1'b1;
        end
      end
    end
  endtask
  task rc(input [7:0] a, input [31:0] exp);
    begin
      rd(a, rv, rr);
      check(rv, exp);
    end
  endtask
  // Outputs are steady once the new settings reach the pipeline
  task oc(input [15:0] ea, input [15:0] eb);
    begin
      repeat (8) @(posedge clk);
      #1;
      check({16'h0000, ch_a_data}, {16'h0000, ea});
      check({16'h0000, ch_b_data}, {16'h0000, eb});
    end
  endtask
  // One head pop lets exactly one sample step into the freed tail
  task pop;
    begin
      @(posedge clk);
      out_ready <= 1'b1;
      @(posedge clk);
      out_ready <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  initial begin
    err_count = 0;
    n_tests = 0;
    {rstn, awvalid, wvalid, bready, arvalid, rready, en, fire} = 8'h00;
    {awaddr, araddr, wdata, lane_i, lane_q} = 176'h0;
    wstrb = 4'hF;
    out_ready = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rc(8'h00, 32'h0000_0000);
    rd(8'h0C, rv, rr);
    check({30'h0, rr}, 32'h0000_0002);
    wr(8'h0C, 32'h0000_FFFF);
    check({30'h0, br}, 32'h0000_0002);
    rc(8'h08, 32'h0000_0000);
    wr(8'h28, 32'h0123_4567);
    check({30'h0, br}, 32'h0000_0000);
    rc(8'h28, 32'h0123_4567);
    wr(8'h28, 32'h0000_0000);
    out_ready <= 1'b1;
    wr(8'h04, 32'h0000_4000);
    wr(8'h08, 32'h0000_2000);
    wr(8'h00, 32'h0000_41F2);
    oc(16'h1FFF, 16'h0FFF);
    wr(8'h00, 32'h0000_3FF2);
    oc(16'h5FFC, 16'h3FFE);
    wr(8'h00, 32'h0000_3FF3);
    oc(16'h7FFF, 16'h7FFE);
    wr(8'h04, 32'h8000_C000);
    wr(8'h08, 32'h8000_A000);
    wr(8'h00, 32'h0000_41F0);
    oc(16'h1FFF, 16'h0FFF);
    wr(8'h04, 32'h4000_4000); // Half scale keeps I plus Q clear of clipping
    wr(8'h08, 32'h0000_2000);
    wr(8'h00, 32'h0000_41F2);
    oc(16'h1FFF, 16'h0FFF);
    wr(8'h14, 32'h4000_0000);
    oc(16'hE000, 16'h0FFF);
    wr(8'h14, 32'h0000_0000);
    lane_i <= 64'h0000_0000_4000_2000;
    en <= 1'b1;
    wr(8'h00, 32'h0000_1202);
    oc(16'h1FFF, 16'h0FFF);
    en <= 1'b0;
    wr(8'h14, 32'h0000_0001);
    wr(8'h00, 32'h0000_00F2);
    out_ready <= 1'b0;
    repeat (4) @(posedge clk);
    rc(8'h30, 32'h0000_0003);
    wr(8'h00, 32'h0001_00F2);
    rc(8'h34, 32'h0000_0000);
    pop;
    rc(8'h34, 32'h0001_0000);
    pop;
    rc(8'h34, 32'h0002_0000);
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (6) @(posedge clk);
    rc(8'h34, 32'h0000_0000);
    rc(8'h30, 32'h0000_0203);
    final_report;
  end
endmodule // multitone_duc_test
